// >>> logic/gpe_event_steer.sv
// Purpose: general purpose event steering for downstream ports 2 and 4
// Assumes: port event requests, warm reset and pin function select are on CLK_SYS
// Notes: control bits survive warm reset; only SYS_RST clears them
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`include "gpe_regs.svh"

// Functional notes
// - pin active low, or high when inverted
// - port 2 redirect suppresses native notifications
// - port 4 redirect suppresses native notifications
// - pin driven only in alternate function
// - port 2 status shows its pin signalling
// - port 4 status shows its pin signalling
// - status never set without redirect enable
// - control bits reset zero, survive warm reset
module gpe_event_steer (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire gpe_pkg::gpe_addr_t WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire gpe_pkg::gpe_word_t WB_DAT_I,
  output gpe_pkg::gpe_word_t WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic WARM_RST,
  input wire logic GPIO7_ALT_EN,
  input wire logic P2_HP_EVT,
  input wire logic P4_HP_EVT,
  output logic P2_NATIVE_EN,
  output logic P4_NATIVE_EN,
  output logic GPIO7_O,
  output logic GPIO7_OE
);
  // all properties below share the system clock and the cold reset
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  // sticky control bits
  logic inv_q;
  logic redir2_q;
  logic redir4_q;
  // per-port activity from the routers
  logic act2_q;
  logic act4_q;
  // registered bus answer
  logic ack_q;
  gpe_pkg::gpe_word_t dat_q;

  // bus decode; a request is served in the cycle ack is low
  wire logic bus_req = WB_CYC_I & WB_STB_I & ~ack_q;
  wire logic hit_ctl = (WB_ADR_I == `GPE_CTL_OFS);
  wire logic hit_sts = (WB_ADR_I == `GPE_STS_OFS);
  // only byte lane 0 carries control bits
  wire logic wr_ctl = bus_req & WB_WE_I & hit_ctl & WB_SEL_I[0];

  // register read images; reserved bits read zero
  function automatic gpe_pkg::gpe_word_t pack3(input logic b0, input logic b2, input logic b4);
    gpe_pkg::gpe_word_t w;
    // start from zero so every reserved bit reads zero
    w = 32'h0000_0000;
    w[`GPE_INV_BIT] = b0;
    w[`GPE_P2_BIT] = b2;
    w[`GPE_P4_BIT] = b4;
    return w;
  endfunction : pack3

  // control reads back what software wrote; status shows live flags
  wire gpe_pkg::gpe_word_t ctl_img = pack3(inv_q, redir2_q, redir4_q);
  wire gpe_pkg::gpe_word_t sts_img = pack3(1'b0, act2_q, act4_q);
  // unmapped reads answer zero, unmapped writes are dropped
  wire gpe_pkg::gpe_word_t rd_mux = hit_ctl ? ctl_img : (hit_sts ? sts_img : 32'h0000_0000);

  // any redirected port asserting
  wire logic any_act = act2_q | act4_q;
  // drive the inactive level too, so the pin never floats while owned
  wire logic pin_lvl = inv_q ? any_act : ~any_act;

  // control register: warm reset is deliberately absent here
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      inv_q <= 1'b0;
      redir2_q <= 1'b0;
      redir4_q <= 1'b0;
    end else if (wr_ctl) begin
      // software write lands at the edge that takes the request
      inv_q <= WB_DAT_I[`GPE_INV_BIT];
      redir2_q <= WB_DAT_I[`GPE_P2_BIT];
      redir4_q <= WB_DAT_I[`GPE_P4_BIT];
    end
  end

  // bus answer: one-cycle ack, registered read data
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      // no answer and a zero word while in reset
      ack_q <= 1'b0;
      dat_q <= `GPE_STS_RST;
    end else begin
      ack_q <= bus_req;
      // the word stands until the next request replaces it
      if (bus_req) begin
        dat_q <= rd_mux;
      end
    end
  end

  // pin driver; released entirely when the pin is plain gpio
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      // released, parked at the idle high level
      GPIO7_O <= 1'b1;
      GPIO7_OE <= 1'b0;
    end else begin
      // registered so the pad never sees a decode glitch
      GPIO7_O <= GPIO7_ALT_EN ? pin_lvl : 1'b1;
      GPIO7_OE <= GPIO7_ALT_EN;
    end
  end

  // port 2 steering
  gpe_port_route u_port2 (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .warm_rst(WARM_RST),
    .evt_req(P2_HP_EVT),
    .redirect(redir2_q),
    .active_q(act2_q),
    .native_en_q(P2_NATIVE_EN)
  );

  // port 4 steering
  gpe_port_route u_port4 (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .warm_rst(WARM_RST),
    .evt_req(P4_HP_EVT),
    .redirect(redir4_q),
    .active_q(act4_q),
    .native_en_q(P4_NATIVE_EN)
  );

  // bus outputs come straight from their flops
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  // pin level follows polarity and activity one cycle later
  a_pin_polarity: assert property (
    $past(GPIO7_ALT_EN) |-> GPIO7_O == ($past(inv_q) ? $past(any_act) : !$past(any_act)))
    else $error("event pin level wrong for polarity");

  // port 2 redirect kills native notification
  a_p2_native_off: assert property (redir2_q |=> !P2_NATIVE_EN)
    else $error("port 2 native notification not suppressed");

  // port 4 redirect kills native notification
  a_p4_native_off: assert property (redir4_q |=> !P4_NATIVE_EN)
    else $error("port 4 native notification not suppressed");

  // port 2 native notification returns once redirect is clear
  a_p2_native_on: assert property (!redir2_q |=> P2_NATIVE_EN)
    else $error("port 2 native notification blocked without redirect");

  // port 4 native notification returns once redirect is clear
  a_p4_native_on: assert property (!redir4_q |=> P4_NATIVE_EN)
    else $error("port 4 native notification blocked without redirect");

  // pin released when not alternate function
  a_pin_alt_only: assert property (!GPIO7_ALT_EN |=> !GPIO7_OE && GPIO7_O)
    else $error("event pin driven outside alternate function");

  // the pin is owned whenever the alternate function is chosen
  a_pin_owned: assert property (GPIO7_ALT_EN |=> GPIO7_OE)
    else $error("event pin not driven in alternate function");

  // idle owned pin sits at the inactive level of the polarity
  a_pin_inactive: assert property (
    GPIO7_ALT_EN && !any_act |=> GPIO7_O == !$past(inv_q))
    else $error("idle event pin not at inactive level");

  // redirected port 2 event shows in status and asserts the pin
  sequence s_p2_evt;
    redir2_q && P2_HP_EVT && !WARM_RST && GPIO7_ALT_EN;
  endsequence
  // the pin check skips a cycle in which the pin was handed back to gpio,
  // and takes the polarity that stood when the pin level was launched
  a_p2_status_pin: assert property (
    s_p2_evt |=> act2_q ##1 (!$past(GPIO7_ALT_EN) || GPIO7_O == $past(inv_q)))
    else $error("port 2 event not reported");

  // redirected port 4 event shows in status
  a_p4_status: assert property (redir4_q && P4_HP_EVT && !WARM_RST |=> act4_q)
    else $error("port 4 event not reported");

  // status never up without redirect
  a_p4_gated: assert property (act4_q |-> $past(redir4_q))
    else $error("port 4 status set without redirect");

  // port 2 status only while its redirect stands
  a_p2_gated: assert property (act2_q |-> $past(redir2_q))
    else $error("port 2 status set without redirect");

  // redirected port 4 event shows in status and asserts the pin
  sequence s_p4_evt;
    redir4_q && P4_HP_EVT && !WARM_RST && GPIO7_ALT_EN;
  endsequence
  a_p4_status_pin: assert property (
    s_p4_evt |=> act4_q ##1 (!$past(GPIO7_ALT_EN) || GPIO7_O == $past(inv_q)))
    else $error("port 4 event not reported on the pin");

  // control bits hold through warm reset
  a_sticky_warm: assert property (
    WARM_RST && !wr_ctl |=> $stable(ctl_img) && !act2_q && !act4_q)
    else $error("control lost or status kept in warm reset");

  // status read returns live flags
  sequence s_sts_read;
    bus_req && hit_sts && !WB_WE_I;
  endsequence
  a_sts_read: assert property (
    s_sts_read |=> WB_ACK_O && WB_DAT_O[`GPE_P2_BIT] == $past(act2_q)
      && WB_DAT_O[`GPE_P4_BIT] == $past(act4_q))
    else $error("status read data wrong");

  // a write without byte lane 0 leaves the sticky bits alone
  a_ctl_lane_hold: assert property (
    bus_req && WB_WE_I && hit_ctl && !WB_SEL_I[0] |=> $stable(ctl_img))
    else $error("control changed by a write without lane 0");
endmodule : gpe_event_steer

// >>> include/gpe_regs.svh
// Purpose: register offsets, field positions and reset values of the event steering block
// Assumes: byte addresses on a 12-bit wishbone address
// Notes: definitions only
`ifndef GPE_REGS_SVH
`define GPE_REGS_SVH

// register byte offsets
`define GPE_CTL_OFS 12'h450
`define GPE_STS_OFS 12'h454

// field positions, shared by control and status
`define GPE_INV_BIT 0
`define GPE_P2_BIT 2
`define GPE_P4_BIT 4

// reset values
`define GPE_CTL_RST 32'h0000_0000
`define GPE_STS_RST 32'h0000_0000

`endif

// >>> include/gpe_pkg.sv
// Purpose: shared types of the event steering block
// Assumes: 32-bit wishbone data
// Notes: constants live in gpe_regs.svh
package gpe_pkg;
  typedef logic [31:0] gpe_word_t; // one register word
  typedef logic [11:0] gpe_addr_t; // byte address
endpackage : gpe_pkg

// >>> logic/gpe_port_route.sv
// Purpose: per-port steering of downstream events onto the general event output
// Assumes: event request comes from port logic on CLK_SYS
// Notes: active flag is non-sticky, cleared by warm reset
`timescale 1ns/1ps
module gpe_port_route (
  input wire logic clk,
  input wire logic rst,
  input wire logic warm_rst,
  input wire logic evt_req,
  input wire logic redirect,
  output logic active_q,
  output logic native_en_q
);
  // event is reported through the shared pin only when redirected
  wire logic active_d = redirect & evt_req & ~warm_rst;
  // native notifications live only while not redirected
  wire logic native_d = ~redirect;

  // status and native enable flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_q <= 1'b0;
      native_en_q <= 1'b1;
    end else begin
      active_q <= active_d;
      native_en_q <= native_d;
    end
  end

  // a port never shows activity without its redirect enable
  a_gated_status: assert property (@(posedge clk) disable iff (rst)
    active_q |-> $past(redirect) && $past(evt_req))
    else $error("port active without redirect and event");
endmodule : gpe_port_route

// >>> dv/gpe_sys_monitor.sv
// Purpose: system-side watcher of the shared event pin
// Assumes: released pin is pulled to its inactive level
// Notes: flags an event while the driven pin sits at its active level
`timescale 1ns/1ps
module gpe_sys_monitor (
  input wire logic clk,
  input wire logic pin_lvl,
  input wire logic pin_drv,
  input wire logic inv,
  output logic seen_q
);
  // a released pin reads inactive, so no false event is flagged
  always_ff @(posedge clk) begin
    seen_q <= pin_drv ? (pin_lvl == inv) : 1'b0;
  end
endmodule : gpe_sys_monitor

// >>> dv/testbench.sv
// Purpose: random and corner checks of the event steering block
// Assumes: one 250 MHz clock, classic single wishbone cycles
// Notes: expectations come from bench variables and functions only
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0; // system clock
  logic rst = 1'b1; // fundamental reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, warm = 1'b0;
  logic alt = 1'b0, e2 = 1'b0, e4 = 1'b0; // pin function and port events
  gpe_pkg::gpe_addr_t adr = 12'h000;
  gpe_pkg::gpe_word_t wdat = 32'h0000_0000, rdat, rd, c;
  logic ack, n2, n4, po, poe, seen;
  logic [3:0] sel = 4'hF, lane = 4'hF; // lanes on the bus, lanes of the next request
  int err_count = 0, samples_checked = 0, i;
  integer seed = 32'h9ab4; // fixed, so every run repeats
  initial forever #2 clk = ~clk;
  gpe_event_steer dut_u (.CLK_SYS(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .WARM_RST(warm), .GPIO7_ALT_EN(alt), .P2_HP_EVT(e2), .P4_HP_EVT(e4),
    .P2_NATIVE_EN(n2), .P4_NATIVE_EN(n4), .GPIO7_O(po), .GPIO7_OE(poe));
  gpe_sys_monitor mon_u (.clk(clk), .pin_lvl(po), .pin_drv(poe), .inv(c[0]), .seen_q(seen));
  // status expected from control and the event levels
  function automatic gpe_pkg::gpe_word_t exp_sts(gpe_pkg::gpe_word_t k, logic a, logic b);
    return {27'h0, k[4] & b, 1'b0, k[2] & a, 2'h0};
  endfunction : exp_sts
  task automatic chk(string nm, gpe_pkg::gpe_word_t e, gpe_pkg::gpe_word_t g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chb(string nm, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chb
  // one classic cycle; held until ack is sampled high
  task automatic wb(logic w, gpe_pkg::gpe_addr_t a, gpe_pkg::gpe_word_t d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= lane;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      err_count++;
      $display("ERROR bus ack expected 1 seen 0");
    end
  endtask : wb
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // watchdog: the whole run needs well under this span
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    finish_test();
  end
  initial begin
    c = 32'h0000_0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 12'h450, 32'h0); chk("ctl reset", 32'h0, rd);
    wb(1'b0, 12'h454, 32'h0); chk("sts reset", 32'h0, rd);
    wb(1'b1, 12'h458, 32'hFFFF_FFFF);
    wb(1'b0, 12'h458, 32'h0); chk("unmapped", 32'h0, rd);
    for (i = 0; i < 12; i++) begin
      c = $random(seed);
      if (i == 0) c = 32'hFFFF_FFFF; // all enables, reserved bits set
      wb(1'b1, 12'h450, c);
      c = c & 32'h0000_0015;
      {alt, e2, e4} <= (i == 0) ? 3'h7 : 3'($random(seed));
      wb(1'b1, 12'h454, 32'hFFFF_FFFF); // status is read-only
      repeat (3) @(posedge clk);
      chb("native p2", ~c[2], n2);
      chb("native p4", ~c[4], n4);
      chb("pin drive", alt, poe);
      if (alt) chb("pin level", (|exp_sts(c, e2, e4)) ? c[0] : ~c[0], po);
      chb("seen", alt & (|exp_sts(c, e2, e4)), seen);
      wb(1'b0, 12'h454, 32'h0); chk("status", exp_sts(c, e2, e4), rd);
      wb(1'b0, 12'h450, 32'h0); chk("control", c, rd);
    end
    // warm reset must leave the control bits alone
    warm <= 1'b1;
    @(posedge clk);
    warm <= 1'b0;
    wb(1'b0, 12'h450, 32'h0); chk("ctl warm", c, rd);
    // a write without byte lane 0 must not reach the control bits
    lane = 4'hE;
    wb(1'b1, 12'h450, ~c);
    lane = 4'hF;
    wb(1'b0, 12'h450, 32'h0); chk("ctl lane", c, rd);
    // a second fundamental reset brings every control bit back to zero
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 12'h450, 32'h0); chk("ctl cold", 32'h0, rd);
    chb("native p2 cold", 1'b1, n2);
    finish_test();
  end
endmodule : testbench
